// ---- bench/adc_readout_assertions.sv ----
/*
  Checker of the link between the converter's readout logic and its host.
  Assumes the bench feeds it the link's pins, the chain strap and the
  device's sleep flag, all in the single system clock domain.
*/
`timescale 1ns/1ps

module adc_readout_assertions #(
  parameter int CONV_CNT = 60
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic convert_start,
  input wire logic sck,
  input wire logic read_enable_or_chain_input,
  input wire logic busy,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic chain_mode_i,
  input wire logic asleep_o,
  input wire logic sleep_pending_o,
  input wire logic result_ready_o
);
  // ==========================================================
  // Helper logic
  int unsigned busy_run_r;

  // The run length is sampled at the fall, so it holds the busy cycles.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || !busy) begin
      busy_run_r <= 0;
    end else begin
      busy_run_r <= busy_run_r + 1;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  // ==========================================================
  // Properties
  property p_start_to_busy;
    $rose(convert_start) && !busy && !asleep_o |-> ##[2:5] $rose(busy);
  endproperty
  property p_busy_length;
    $fell(busy) |-> busy_run_r >= CONV_CNT - 1 && busy_run_r <= CONV_CNT + 1;
  endproperty
  property p_float_deselected;
    (!chain_mode_i && read_enable_or_chain_input) [*6] |-> !sdo_oe;
  endproperty
  property p_drive_selected;
    (!chain_mode_i && !read_enable_or_chain_input) [*6] |-> sdo_oe;
  endproperty
  property p_chain_drives;
    chain_mode_i [*6] |-> sdo_oe;
  endproperty
  // Long enough after a rise or a busy fall for every shift to have landed.
  property p_sdo_holds;
    (sdo_oe && !sck && !busy) [*6] |=> $stable(sdo);
  endproperty
  property p_sleep_at_fall;
    $rose(asleep_o) |-> !busy && ($past(busy, 1) || $past(busy, 2) ||
      $past(busy, 3));
  endproperty
  property p_wake_on_sck;
    asleep_o && $rose(sck) |-> ##[1:6] !asleep_o;
  endproperty
  property p_read_after_conv;
    !read_enable_or_chain_input |-> !busy;
  endproperty
  property p_ready_at_fall;
    $fell(busy) |-> result_ready_o;
  endproperty
  property p_sleep_requested;
    $rose(asleep_o) |-> $past(sleep_pending_o);
  endproperty

  a_start_to_busy: assert property (p_start_to_busy)
    else $error("busy did not rise after convert start");
  a_busy_length: assert property (p_busy_length)
    else $error("conversion length off");
  a_float_deselected: assert property (p_float_deselected)
    else $error("serial output driven while deselected");
  a_drive_selected: assert property (p_drive_selected)
    else $error("serial output not driven while selected");
  a_chain_drives: assert property (p_chain_drives)
    else $error("serial output not driven in chain mode");
  a_sdo_holds: assert property (p_sdo_holds)
    else $error("serial output moved without a clock rise");
  a_sleep_at_fall: assert property (p_sleep_at_fall)
    else $error("sleep entered away from busy fall");
  a_wake_on_sck: assert property (p_wake_on_sck)
    else $error("clock rise did not wake the device");
  a_read_after_conv: assert property (p_read_after_conv)
    else $error("readout selected during conversion");
  a_ready_at_fall: assert property (p_ready_at_fall)
    else $error("result not flagged at busy fall");
  a_sleep_requested: assert property (p_sleep_requested)
    else $error("sleep entered without a request");

  c_conversion: cover property ($fell(busy));
  c_sleep: cover property ($rose(asleep_o));
  c_chain_shift: cover property (chain_mode_i && $rose(sck));
endmodule

// ---- bench/tb_top.sv ----
/*
  Testbench joining host and device ends over one link, driven through
  the host's Wishbone registers.
  Assumes the design files and the register map of the shared header.
*/
`timescale 1ns/1ps

module tb_top;
  localparam int CONV = 8;
  logic clk_sys_i;
  logic resetn_i;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [3:0] wb_adr;
  logic [31:0] wb_wdat;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [15:0] sample;
  logic chain_mode;
  logic busy;
  logic asleep;
  logic pending;
  logic ready;
  logic [31:0] rd;
  logic [15:0] pat [3] = '{16'ha5c3, 16'h8001, 16'h7ffe};
  int n_errors;
  int n_compared;
  int cycles;

  // ==========================================================
  // Design and checker
  adc_link_if adc_link_if_i ();
  adc_readout_device #(.CONV_CNT(CONV)) adc_readout_device_i (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link(adc_link_if_i.dev),
    .sample_i(sample), .chain_mode_i(chain_mode), .busy_o(busy),
    .asleep_o(asleep), .sleep_pending_o(pending), .result_ready_o(ready));
  adc_readout_host #(.WAKE_CNT(4)) adc_readout_host_i (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link(adc_link_if_i.host),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
  adc_readout_assertions #(.CONV_CNT(CONV)) adc_readout_assertions_i (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .convert_start(adc_link_if_i.convert_start), .sck(adc_link_if_i.sck),
    .read_enable_or_chain_input(adc_link_if_i.read_enable_or_chain_input),
    .busy(adc_link_if_i.busy),
    .sdo(adc_link_if_i.sdo), .sdo_oe(adc_link_if_i.sdo_oe),
    .chain_mode_i(chain_mode), .asleep_o(asleep),
    .sleep_pending_o(pending), .result_ready_o(ready));

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // The request holds until ack is sampled; that edge also takes the data.
  task automatic wb_xfer(input logic we, input logic [3:0] adr,
                         input logic [31:0] dat);
    @(posedge clk_sys_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= dat;
    do @(posedge clk_sys_i); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wait_idle();
    do wb_xfer(1'b0, 4'h4, 32'h0); while (rd[0] !== 1'b0);
  endtask

  // The sample is set before the start so it stands at conversion end.
  task automatic readout(input logic [15:0] s);
    sample <= s;
    wb_xfer(1'b1, 4'h0, 32'h1);
    wait_idle();
    wb_xfer(1'b0, 4'h8, 32'h0);
  endtask

  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog and sequence
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    n_errors = 0;
    n_compared = 0;
    cycles = 0;
    resetn_i = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 4'h0;
    wb_wdat = 32'h0;
    sample = 16'h0;
    chain_mode = 1'b0;
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    wb_xfer(1'b0, 4'hc, 32'h0);
    check("cfg reset", rd, 32'h1);
    wb_xfer(1'b0, 4'h4, 32'h0);
    check("status reset", rd, 32'h0);
    wb_xfer(1'b0, 4'h0, 32'h0);
    check("ctrl read", rd, 32'h0);
    check("oe idle", {31'h0, adc_link_if_i.sdo_oe}, 32'h0);
    wb_xfer(1'b1, 4'h3, 32'h7);
    wb_xfer(1'b0, 4'h6, 32'h0);
    check("unmapped", rd, 32'h0);
    wb_xfer(1'b0, 4'hc, 32'h0);
    check("cfg kept", rd, 32'h1);
    $display("test registers done");
    foreach (pat[i]) begin
      readout(pat[i]);
      check("word", {16'h0, rd[15:0]}, {16'h0, pat[i]});
    end
    $display("test normal single word done");
    wb_xfer(1'b1, 4'hc, 32'h2);
    readout(16'h3c96);
    check("two words", rd, {16'h3c96, 16'h0});
    wb_xfer(1'b1, 4'hc, 32'h0);
    readout(16'h1234);
    check("no shift", rd, {16'h3c96, 16'h0});
    // That start had no clock after it, so the next one would request
    // sleep; a wake clock cancels the pending start.
    wb_xfer(1'b1, 4'h0, 32'h4);
    wait_idle();
    $display("test word counts done");
    chain_mode <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    check("chain oe", {31'h0, adc_link_if_i.sdo_oe}, 32'h1);
    wb_xfer(1'b1, 4'hc, 32'h2);
    readout(16'hc3a5);
    check("chain", rd, {16'hc3a5, 16'h0});
    chain_mode <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    check("normal oe", {31'h0, adc_link_if_i.sdo_oe}, 32'h0);
    $display("test chain done");
    wb_xfer(1'b1, 4'hc, 32'h1);
    wb_xfer(1'b1, 4'h0, 32'h2);
    wait_idle();
    check("asleep", {31'h0, asleep}, 32'h1);
    check("sleep status", rd, 32'h6);
    wb_xfer(1'b1, 4'h0, 32'h4);
    wait_idle();
    check("awake", {31'h0, asleep}, 32'h0);
    check("wake status", {31'h0, rd[2]}, 32'h0);
    readout(16'h5a5a);
    check("after wake", {16'h0, rd[15:0]}, 32'h5a5a);
    $display("test sleep done");
    wrap_up();
  end
endmodule

// ---- hdl/adc_link_if.sv ----
/*
  Pins between the converter's readout logic and its host.
  Assumes the bench instantiates it once per converter; the shared serial
  output is resolved here from its enable, idling high when undriven.
*/
`timescale 1ns/1ps

interface adc_link_if;
  logic convert_start;
  logic sck;
  logic read_enable_or_chain_input;
  logic busy;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;

  // An undriven line is read as high, as a pull-up would leave it.
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport dev (
    input convert_start,
    input sck,
    input read_enable_or_chain_input,
    output busy,
    output sdo,
    output sdo_oe
  );

  modport host (
    output convert_start,
    output sck,
    output read_enable_or_chain_input,
    input busy,
    input sdo_line
  );
endinterface

// ---- hdl/adc_readout_cfg.svh ----
/*
  Shared constants of the serial result readout: frame size, conversion
  and link timing, and the host controller's register map.
  Assumes inclusion by bare name from the device and host design files.
*/
`ifndef ADC_READOUT_CFG_SVH
`define ADC_READOUT_CFG_SVH

`define RES_BITS 16
`define CLK_PERIOD_NS 25
`define CONV_TIME_NS 1500
`define CONV_CYCLES (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define WAKE_TIME_NS 1000
`define WAKE_CYCLES (`WAKE_TIME_NS / `CLK_PERIOD_NS)
`define SCK_HALF_CYCLES 8
`define SEL_SETTLE_CYCLES 6
`define CNT_W 16
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_DATA 4'h8
`define REG_CFG 4'hc
`define CTRL_GO 0
`define CTRL_SLEEP 1
`define CTRL_WAKE 2
`define STAT_ACTIVE 0
`define STAT_DONE 1
`define STAT_ASLEEP 2
`define CFG_WORDS_W 3
`define CFG_WORDS_RST 3'h1
`define SLEEP_CONVS 2'h2

`endif

// ---- hdl/adc_readout_device.sv ----
/*
  Device end of the serial readout: conversion timing, busy, the result
  shift register with normal and chain modes, and sleep entry and wake.
  Assumes every pin arrives asynchronously to clk_sys_i and that the
  analog result is presented on sample_i when the conversion ends.
*/
`timescale 1ns/1ps
`include "adc_readout_cfg.svh"

// Contract
// RULE1 - Shift result out only while output enabled.
// RULE2 - Output changes on rising serial clock edge.
// RULE3 - MSB stays valid until first rising edge.
// RULE4 - Host clocks fast enough for full throughput.
// RULE5 - Host reads after conversion, not during.
// RULE6 - Chain select low means normal mode.
// RULE7 - Normal mode: read enable high floats output.
// RULE8 - Enabled output shows new MSB at busy fall.
// RULE9 - Host selects one shared device at a time.
// RULE10 - Read enable low drives MSB immediately.
// RULE11 - Chain mode: output always on, pin inputs.
// RULE12 - Upstream MSB appears after sixteen clocks.
// RULE13 - Upstream MSB captured on first rising edge.
// RULE14 - Two starts without clock request sleep.
// RULE15 - Sleep begins at last conversion's busy fall.
// RULE16 - Asleep, any rising serial clock wakes.
// RULE17 - Host waits wake delay before converting.
// RULE18 - Start edge converts; busy high; no restart.
// RULE19 - Conversion finishes within its maximum time.
// RULE20 - Host keeps start quiet during conversion.
// RULE21 - Sixteen bits MSB first, chain bits follow.
// RULE22 - Clock edge between starts cancels sleep.
module adc_readout_device #(
  parameter int RES_W = `RES_BITS,
  parameter int CONV_CNT = `CONV_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  adc_link_if.dev link,
  input wire logic [RES_W-1:0] sample_i,
  input wire logic chain_mode_i,
  output logic busy_o,
  output logic asleep_o,
  output logic sleep_pending_o,
  output logic result_ready_o
);

  localparam int CW = $clog2(CONV_CNT + 1);
  localparam logic [CW-1:0] CONV_LOAD = CW'(CONV_CNT - 1);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic start_s1_r, start_s2_r, start_d_r;
  logic sck_s1_r, sck_s2_r, sck_d_r;
  logic ren_s1_r, ren_s2_r;
  logic chain_s1_r, chain_s2_r;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      start_s1_r <= 1'b0;
      start_s2_r <= 1'b0;
      start_d_r <= 1'b0;
    end else begin
      start_s1_r <= link.convert_start;
      start_s2_r <= start_s1_r;
      start_d_r <= start_s2_r;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_d_r <= 1'b0;
    end else begin
      sck_s1_r <= link.sck;
      sck_s2_r <= sck_s1_r;
      sck_d_r <= sck_s2_r;
    end
  end

  // Read enable idles high, so reset leaves the output floating.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ren_s1_r <= 1'b1;
      ren_s2_r <= 1'b1;
      chain_s1_r <= 1'b0;
      chain_s2_r <= 1'b0;
    end else begin
      ren_s1_r <= link.read_enable_or_chain_input;
      ren_s2_r <= ren_s1_r;
      chain_s1_r <= chain_mode_i;
      chain_s2_r <= chain_s1_r;
    end
  end

  logic start_rise;
  logic sck_rise;
  logic chain_on;
  logic out_enable;

  assign start_rise = start_s2_r & ~start_d_r;
  assign sck_rise = sck_s2_r & ~sck_d_r;
  assign chain_on = chain_s2_r;
  // Chain mode keeps the output on; normal mode follows read enable.
  assign out_enable = chain_on | ~ren_s2_r; // [RULE6] [RULE7] [RULE11]

  // ==========================================================
  // Conversion and sleep sequencing
  // ==========================================================
  adc_readout_pkg::dev_state_t state_r;
  logic [CW-1:0] conv_cnt_r;
  logic conv_last;
  logic pend_r;
  logic sleep_req_r;

  assign conv_last = (state_r == adc_readout_pkg::DEV_CONV) &&
                     (conv_cnt_r == '0);

  // Start edges during a conversion or in sleep start no new conversion.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_r <= adc_readout_pkg::DEV_NAP;
    end else begin
      unique case (state_r)
        adc_readout_pkg::DEV_NAP: begin
          if (start_rise) begin
            state_r <= adc_readout_pkg::DEV_CONV; // [RULE18]
          end
        end
        adc_readout_pkg::DEV_CONV: begin
          if (conv_last) begin
            state_r <= sleep_req_r ? adc_readout_pkg::DEV_SLEEP :
                       adc_readout_pkg::DEV_NAP; // [RULE15] [RULE22]
          end
        end
        adc_readout_pkg::DEV_SLEEP: begin
          if (sck_rise) begin
            state_r <= adc_readout_pkg::DEV_NAP; // [RULE16]
          end
        end
        default: begin
          state_r <= adc_readout_pkg::DEV_NAP;
        end
      endcase
    end
  end

  // The count is the longest time in whole cycles, rounded down.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      conv_cnt_r <= '0;
    end else if (state_r == adc_readout_pkg::DEV_NAP && start_rise) begin
      conv_cnt_r <= CONV_LOAD; // [RULE19]
    end else if (conv_cnt_r != '0) begin
      conv_cnt_r <= conv_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      busy_o <= 1'b0;
    end else if (state_r == adc_readout_pkg::DEV_NAP && start_rise) begin
      busy_o <= 1'b1; // [RULE18]
    end else if (conv_last) begin
      busy_o <= 1'b0;
    end
  end

  // A start edge in the same cycle as a clock edge counts after it, so
  // it opens a new pair rather than completing the old one.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pend_r <= 1'b0;
      sleep_req_r <= 1'b0;
    end else if (state_r == adc_readout_pkg::DEV_SLEEP ||
                 (conv_last && sleep_req_r)) begin
      pend_r <= 1'b0;
      sleep_req_r <= 1'b0;
    end else begin
      if (sck_rise) begin
        pend_r <= 1'b0; // [RULE22]
        sleep_req_r <= 1'b0; // [RULE22]
      end
      if (start_rise) begin
        pend_r <= 1'b1;
        if (pend_r && !sck_rise) begin
          sleep_req_r <= 1'b1; // [RULE14]
        end
      end
    end
  end

  // ==========================================================
  // Result shift register
  // ==========================================================
  logic [RES_W-1:0] shift_r;
  logic shift_in;

  // Normal mode shifts in zeros; chain mode appends upstream bits.
  assign shift_in = chain_on ? ren_s2_r : 1'b0; // [RULE13] [RULE21]

  // The MSB sits at the top from the load on, so it is on the pin the
  // moment the output is enabled and stays until the first clock edge.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      shift_r <= '0;
    end else if (conv_last) begin
      shift_r <= sample_i; // [RULE8] [RULE3]
    end else if (sck_rise && out_enable &&
                 state_r != adc_readout_pkg::DEV_SLEEP) begin
      shift_r <= {shift_r[RES_W-2:0], shift_in}; // [RULE1] [RULE2] [RULE12]
    end
  end

  logic sdo_r;
  logic sdo_oe_r;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else begin
      sdo_r <= shift_r[RES_W-1]; // [RULE21]
      sdo_oe_r <= out_enable; // [RULE10]
    end
  end

  assign link.sdo = sdo_r;
  assign link.sdo_oe = sdo_oe_r;
  assign link.busy = busy_o;

  // ==========================================================
  // User-side status
  // ==========================================================
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      asleep_o <= 1'b0;
      sleep_pending_o <= 1'b0;
      result_ready_o <= 1'b0;
    end else begin
      asleep_o <= (state_r == adc_readout_pkg::DEV_SLEEP);
      sleep_pending_o <= sleep_req_r;
      result_ready_o <= conv_last;
    end
  end

endmodule

// ---- hdl/adc_readout_host.sv ----
/*
  Host end of the serial readout: a Wishbone classic slave whose commands
  start a conversion and readout, request sleep or wake the converter.
  Assumes one device on the link and a bench that joins both ends.
*/
`timescale 1ns/1ps
`include "adc_readout_cfg.svh"

module adc_readout_host #(
  parameter int WAKE_CNT = `WAKE_CYCLES,
  parameter int SCK_HALF = `SCK_HALF_CYCLES,
  parameter int SEL_SETTLE = `SEL_SETTLE_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  adc_link_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  localparam logic [`CNT_W-1:0] HALF = `CNT_W'(SCK_HALF - 1);
  localparam logic [`CNT_W-1:0] SETTLE = `CNT_W'(SEL_SETTLE - 1);
  localparam logic [`CNT_W-1:0] WAKE = `CNT_W'(WAKE_CNT - 1);

  // ==========================================================
  // Link input synchronisers
  // ==========================================================
  logic busy_s1_r, busy_s2_r, sdo_s1_r, sdo_s2_r;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
      sdo_s1_r <= 1'b0;
      sdo_s2_r <= 1'b0;
    end else begin
      busy_s1_r <= link.busy;
      busy_s2_r <= busy_s1_r;
      sdo_s1_r <= link.sdo_line;
      sdo_s2_r <= sdo_s1_r;
    end
  end

  // ==========================================================
  // Register bus
  // ==========================================================
  adc_readout_pkg::host_state_t state_r;
  logic wb_hit, wr_ctrl, done_r, asleep_r;
  logic [`CFG_WORDS_W-1:0] words_r;
  logic [31:0] data_r;

  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_ctrl = wb_hit & wb_we_i & wb_sel_i[0] &
                   (wb_adr_i == `REG_CTRL);

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          `REG_STATUS: wb_dat_o <= {29'h0, asleep_r, done_r,
                                    state_r != adc_readout_pkg::H_IDLE};
          `REG_DATA: wb_dat_o <= data_r;
          `REG_CFG: wb_dat_o <= {29'h0, words_r};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      words_r <= `CFG_WORDS_RST;
    end else if (wb_hit && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == `REG_CFG) begin
      words_r <= wb_dat_i[`CFG_WORDS_W-1:0];
    end
  end

  // ==========================================================
  // Link sequencer
  // ==========================================================
  logic start_r, sck_r, ren_r, read_r;
  logic [1:0] convs_r;
  logic [`CNT_W-1:0] cnt_r;
  logic [6:0] bits_r;
  logic idle;

  assign idle = (state_r == adc_readout_pkg::H_IDLE);
  assign link.convert_start = start_r;
  assign link.sck = sck_r;
  assign link.read_enable_or_chain_input = ren_r;

  // Start is held high through the whole conversion so that it makes
  // no further transition while the device is busy.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_r <= adc_readout_pkg::H_IDLE;
      start_r <= 1'b0;
      sck_r <= 1'b0;
      ren_r <= 1'b1;
      read_r <= 1'b0;
      convs_r <= '0;
      cnt_r <= '0;
      bits_r <= '0;
      data_r <= '0;
      done_r <= 1'b0;
      asleep_r <= 1'b0;
    end else begin
      unique case (state_r)
        adc_readout_pkg::H_IDLE: begin
          if (wr_ctrl && wb_dat_i[`CTRL_WAKE]) begin
            sck_r <= 1'b1; // [RULE16]
            cnt_r <= HALF;
            state_r <= adc_readout_pkg::H_WAKE;
          end else if (wr_ctrl && (wb_dat_i[`CTRL_GO] ||
                                   wb_dat_i[`CTRL_SLEEP])) begin
            read_r <= ~wb_dat_i[`CTRL_SLEEP];
            convs_r <= wb_dat_i[`CTRL_SLEEP] ? `SLEEP_CONVS : 2'h1;
            done_r <= 1'b0;
            start_r <= 1'b1; // [RULE18]
            state_r <= adc_readout_pkg::H_START;
          end
        end
        // Start drops for one cycle between the two conversions of a
        // sleep request, so the second one is a fresh edge.
        adc_readout_pkg::H_START: begin
          if (!start_r) begin
            start_r <= 1'b1; // [RULE14]
          end else if (busy_s2_r) begin
            state_r <= adc_readout_pkg::H_BUSY;
          end
        end
        adc_readout_pkg::H_BUSY: begin
          if (!busy_s2_r) begin
            start_r <= 1'b0; // [RULE20]
            convs_r <= convs_r - 1'b1;
            if (convs_r != 2'h1) begin
              state_r <= adc_readout_pkg::H_START; // [RULE14]
            end else if (read_r) begin
              ren_r <= 1'b0; // [RULE5] [RULE9]
              cnt_r <= SETTLE;
              state_r <= adc_readout_pkg::H_SEL;
            end else begin
              asleep_r <= 1'b1;
              done_r <= 1'b1;
              state_r <= adc_readout_pkg::H_IDLE;
            end
          end
        end
        adc_readout_pkg::H_SEL: begin
          if (cnt_r == '0) begin
            bits_r <= {words_r, 4'h0};
            cnt_r <= HALF;
            state_r <= adc_readout_pkg::H_SHIFT;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        adc_readout_pkg::H_SHIFT: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (!sck_r && bits_r != '0) begin
            data_r <= {data_r[30:0], sdo_s2_r}; // [RULE2] [RULE3]
            sck_r <= 1'b1; // [RULE4]
            bits_r <= bits_r - 1'b1;
            cnt_r <= HALF;
          end else if (sck_r) begin
            sck_r <= 1'b0;
            cnt_r <= HALF;
          end else begin
            ren_r <= 1'b1; // [RULE9]
            done_r <= 1'b1;
            state_r <= adc_readout_pkg::H_IDLE;
          end
        end
        adc_readout_pkg::H_WAKE: begin
          if (cnt_r == '0) begin
            sck_r <= 1'b0;
            cnt_r <= WAKE;
            state_r <= adc_readout_pkg::H_WWAIT;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        adc_readout_pkg::H_WWAIT: begin
          if (cnt_r == '0) begin
            asleep_r <= 1'b0; // [RULE17]
            state_r <= adc_readout_pkg::H_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          state_r <= adc_readout_pkg::H_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- hdl/adc_readout_pkg.sv ----
/*
  Types of the serial result readout: state encodings of both ends.
  Assumes nothing of its surroundings.
*/
package adc_readout_pkg;

  typedef enum logic [1:0] {
    DEV_NAP = 2'b00,
    DEV_CONV = 2'b01,
    DEV_SLEEP = 2'b10
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_START = 3'b001,
    H_BUSY = 3'b010,
    H_SEL = 3'b011,
    H_SHIFT = 3'b100,
    H_WAKE = 3'b101,
    H_WWAIT = 3'b110
  } host_state_t;

endpackage
